// [inc/pbx_cfg.svh]
/*
  Constants for the peripheral bus slave: octet field positions,
  status bits and synchroniser depth. Assumes nothing else.
*/
`ifndef PBX_CFG_SVH
`define PBX_CFG_SVH

// Selection octet on the first lane
`define SEL_ADDR_MSB 2
`define SEL_ADDR_LSB 0
`define SEL_FAC_MSB 7
`define SEL_FAC_LSB 4

// Bus control octet on the first lane
`define BC_SHARED_BIT 0
`define BC_DIR_IN_BIT 1
`define BC_STREAM_BIT 2
`define BC_RESET 8'h00

// Slave status octet on the second lane
`define ST_SLAVE_END_BIT 0
`define ST_NO_XFER_BIT 1
`define ST_MASTER_END_BIT 2
`define ST_RESET 8'h00

// Flip-flops per pin synchroniser
`define SYNC_STAGES 2

`endif

// [inc/pbx_pkg.sv]
/*
  Types of the peripheral bus slave: controller states and the packed
  state record. Assumes pbx_cfg.svh is not needed here.
*/
package pbx_pkg;

  typedef enum logic [3:0] {
    IDLE, SEL, BC_ACK, XFER, XO_ACK, XI_PUT, XI_ACK, XI_DONE, ST_SET, ST_ACK
  } slave_state_e;

  typedef struct packed {
    slave_state_e state;
    logic busy;
    logic sack;
    logic sstrb;
    logic attn;
    logic [7:0] bc;
    logic [3:0] facility;
    logic [7:0] a_out;
    logic [7:0] b_out;
    logic a_oe;
    logic b_oe;
    logic [15:0] rx_data;
    logic rx_wide;
    logic rx_valid;
    logic tx_ready;
    logic done;
    logic moved;
    logic mstrb_d;
    logic [7:0] status;
  } slave_s;

endpackage : pbx_pkg

// [design/pin_sync.sv]
/*
  Two-stage synchroniser for a group of pins from the cable.
  Assumes each pin is a level held long enough to be seen.
*/
`timescale 1ns/1ns
`include "pbx_cfg.svh"

module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [WIDTH-1:0] pins_i,
  output logic [WIDTH-1:0] sync_o
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_s;

  sync_s r_reg;
  sync_s r_next;

  // First stage feeds only the second
  always_comb begin
    r_next = r_reg;
    r_next.meta = pins_i;
    r_next.stable = r_reg.meta;
  end

  // State register
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign sync_o = r_reg.stable;

endmodule : pin_sync

// [design/bus_slave_ctl.sv]
/*
  Slave end of the handshaked parallel peripheral bus: selection,
  bus control, interlocked or streamed transfers, ending status.
  Assumes the master keeps its own half of the handshake and that
  the cable wiring resolves the lane enables.
*/
// How it works
// [RULE1] Only one of our control lines changes in any cycle.
// [RULE2] Every master line change is answered by our handshake before moving on.
// [RULE3] One master; we never select, we only answer selection.
// [RULE4] Three address bits pick one of eight slaves, four bits one of sixteen facilities.
// [RULE5] All cable lines are shared, daisy-chained, and sampled through synchronisers.
// [RULE6] Bus control and status are interlocked and use one-way lanes only.
// [RULE7] Transfers run split eight-bit or sixteen-bit shared, chosen per transfer.
// [RULE8] Master ends by raising control, slave asks to end by raising attention.
// [RULE9] Each word is fully handshaked unless streaming was requested.
// [RULE10] A dominant slave may run transfers, yet selection stays with the master.
// [RULE11] Shared lanes are never driven by us while the master may drive them.
// [RULE12] Master puts the bus control octet on the first lane.
// [RULE13] Every bus control sequence ends with our status sequence. A deselection mid-sequence returns us to IDLE without one.
// [RULE14] Status follows the transfer at once; master status is optional.
// [RULE15] Our status goes on the second lane, transfer or not.
// [RULE16] Slave-chosen transfer type is optional and not offered here.
// [RULE17] Shared mode moves sixteen bits on both lanes in either direction.
// [RULE18] Split mode: first lane master to slave, second slave to master.
// [RULE19] A busy slave shows busy and refuses selection.
// [RULE20] Master offers maintenance to analyse and recover the interface.
// [RULE21] Payload values never steer the control logic.
// [RULE22] Lanes are driven only in the direction the mode gives us.
`timescale 1ns/1ns
`include "pbx_cfg.svh"

module bus_slave_ctl #(
  parameter logic [2:0] SLAVE_ADDR = 3'h0
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic sel_i,
  input wire logic mctl_i,
  input wire logic mstrb_i,
  input wire logic [7:0] bus_a_i,
  output logic [7:0] bus_a_o,
  output logic bus_a_oe_o,
  input wire logic [7:0] bus_b_i,
  output logic [7:0] bus_b_o,
  output logic bus_b_oe_o,
  output logic sack_o,
  output logic sstrb_o,
  output logic attn_o,
  output logic busy_o,
  input wire logic busy_req_i,
  input wire logic end_req_i,
  output logic selected_o,
  output logic [3:0] facility_o,
  output logic shared_mode_o,
  output logic dir_in_o,
  output logic stream_o,
  output logic [15:0] rx_data_o,
  output logic rx_wide_o,
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  input wire logic [15:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  output logic done_o,
  output logic [7:0] status_o
);

  pbx_pkg::slave_s r_reg;
  pbx_pkg::slave_s r_next;
  logic [18:0] sync_pins;
  logic s_sel;
  logic s_mctl;
  logic s_mstrb;
  logic [7:0] s_a;
  logic [7:0] s_b;
  logic shared;
  logic dir_in;
  logic stream;

  // Every cable input is synchronised before use [RULE5]
  pin_sync #(
    .WIDTH(19)
  ) u_sync (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .pins_i({sel_i, mctl_i, mstrb_i, bus_a_i, bus_b_i}),
    .sync_o(sync_pins)
  );

  assign {s_sel, s_mctl, s_mstrb, s_a, s_b} = sync_pins;

  // Transfer configuration from the latched bus control octet [RULE7]
  assign shared = r_reg.bc[`BC_SHARED_BIT];
  assign dir_in = r_reg.bc[`BC_DIR_IN_BIT];
  assign stream = r_reg.bc[`BC_STREAM_BIT];

  // Lane enables for a transfer in the given mode and direction
  function automatic logic [1:0] lane_oe(input logic sh, input logic din);
    lane_oe = sh ? {din, din} : 2'b01; // {a, b} [RULE18] [RULE22]
  endfunction : lane_oe

  // Controller next state
  always_comb begin
    r_next = r_reg;
    r_next.rx_valid = 1'b0;
    r_next.tx_ready = 1'b0;
    r_next.done = 1'b0;
    r_next.mstrb_d = s_mstrb;
    unique case (r_reg.state)
      pbx_pkg::IDLE: begin
        r_next.busy = busy_req_i; // [RULE19]
        r_next.a_oe = 1'b0;
        r_next.b_oe = 1'b0;
        // Answer selection by the master only [RULE3] [RULE10]
        if (s_sel && !r_reg.busy && s_a[`SEL_ADDR_MSB:`SEL_ADDR_LSB] == SLAVE_ADDR) begin // [RULE4]
          r_next.facility = s_a[`SEL_FAC_MSB:`SEL_FAC_LSB]; // [RULE4]
          r_next.sack = 1'b1;
          r_next.state = pbx_pkg::SEL;
        end
      end
      pbx_pkg::SEL: begin
        r_next.a_oe = 1'b0;
        r_next.b_oe = 1'b0;
        if (s_mctl) begin
          r_next.bc = s_a; // [RULE12]
          r_next.sstrb = 1'b1; // [RULE2] [RULE6]
          r_next.moved = 1'b0;
          r_next.state = pbx_pkg::BC_ACK;
        end
      end
      pbx_pkg::BC_ACK: begin
        if (!s_mctl) begin
          r_next.sstrb = 1'b0; // [RULE2]
          {r_next.a_oe, r_next.b_oe} = lane_oe(shared, dir_in); // [RULE7] [RULE11]
          r_next.state = pbx_pkg::XFER;
        end
      end
      pbx_pkg::XFER: begin
        if (s_mctl) begin
          // Master control closes, on its own or at our attention; status follows at once [RULE8] [RULE13] [RULE14]
          r_next.attn = 1'b0;
          r_next.status = `ST_RESET;
          r_next.status[`ST_SLAVE_END_BIT] = r_reg.attn;
          r_next.status[`ST_MASTER_END_BIT] = !r_reg.attn;
          r_next.status[`ST_NO_XFER_BIT] = !r_reg.moved;
          r_next.a_oe = 1'b0; // Master may present its status [RULE11]
          r_next.b_oe = 1'b1; // Status lane, unidirectional [RULE6] [RULE15] [RULE16]
          r_next.state = pbx_pkg::ST_SET;
        end else if (r_reg.attn) begin
          r_next.attn = 1'b1;
        end else if (end_req_i) begin
          r_next.attn = 1'b1; // [RULE8]
        end else if (!dir_in) begin
          if (stream) begin
            // Streamed words are taken on each strobe rise [RULE9]
            if (s_mstrb && !r_reg.mstrb_d) begin
              r_next.rx_data = shared ? {s_b, s_a} : {8'h00, s_a}; // [RULE17] [RULE21]
              r_next.rx_wide = shared;
              r_next.rx_valid = 1'b1;
              r_next.moved = 1'b1;
            end
          end else if (s_mstrb && rx_ready_i) begin
            r_next.rx_data = shared ? {s_b, s_a} : {8'h00, s_a}; // [RULE17] [RULE18] [RULE21]
            r_next.rx_wide = shared;
            r_next.rx_valid = 1'b1;
            r_next.moved = 1'b1;
            r_next.sstrb = 1'b1; // [RULE9]
            r_next.state = pbx_pkg::XO_ACK;
          end
        end else if (tx_valid_i) begin
          r_next.b_out = tx_data_i[7:0]; // [RULE18]
          r_next.a_out = tx_data_i[15:8]; // [RULE17]
          r_next.rx_wide = shared;
          r_next.tx_ready = 1'b1;
          r_next.moved = 1'b1;
          r_next.state = pbx_pkg::XI_PUT;
        end
      end
      pbx_pkg::XO_ACK: begin
        if (!s_mstrb) begin
          r_next.sstrb = 1'b0; // [RULE2]
          r_next.state = pbx_pkg::XFER;
        end
      end
      pbx_pkg::XI_PUT: begin
        r_next.sstrb = 1'b1; // Data settled one cycle ahead [RULE1]
        r_next.state = pbx_pkg::XI_ACK;
      end
      pbx_pkg::XI_ACK: begin
        if (stream) begin
          r_next.sstrb = 1'b0; // No master answer when streaming [RULE9]
          r_next.state = pbx_pkg::XFER;
        end else if (s_mstrb) begin
          r_next.sstrb = 1'b0; // [RULE2] [RULE9]
          r_next.state = pbx_pkg::XI_DONE;
        end
      end
      pbx_pkg::XI_DONE: begin
        if (!s_mstrb) begin
          r_next.state = pbx_pkg::XFER;
        end
      end
      pbx_pkg::ST_SET: begin
        r_next.b_out = r_reg.status; // [RULE15]
        r_next.sstrb = 1'b1; // [RULE13]
        r_next.state = pbx_pkg::ST_ACK;
      end
      pbx_pkg::ST_ACK: begin
        if (!s_mctl) begin
          r_next.sstrb = 1'b0; // [RULE2]
          r_next.b_oe = 1'b0;
          r_next.done = 1'b1;
          r_next.state = pbx_pkg::SEL;
        end
      end
    endcase
    // Deselection unwinds one control line per cycle [RULE1]
    if (r_reg.state != pbx_pkg::IDLE && !s_sel) begin
      r_next = r_reg;
      r_next.rx_valid = 1'b0;
      r_next.tx_ready = 1'b0;
      r_next.done = 1'b0;
      r_next.mstrb_d = s_mstrb;
      r_next.a_oe = 1'b0; // [RULE22]
      r_next.b_oe = 1'b0;
      r_next.state = pbx_pkg::IDLE;
      if (r_reg.sstrb) begin
        r_next.sstrb = 1'b0;
        r_next.state = r_reg.state;
      end else if (r_reg.attn) begin
        r_next.attn = 1'b0;
        r_next.state = r_reg.state;
      end else begin
        r_next.sack = 1'b0;
      end
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      r_reg <= '{state: pbx_pkg::IDLE, bc: `BC_RESET, status: `ST_RESET, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs from the state record
  assign bus_a_o = r_reg.a_out;
  assign bus_a_oe_o = r_reg.a_oe;
  assign bus_b_o = r_reg.b_out;
  assign bus_b_oe_o = r_reg.b_oe;
  assign sack_o = r_reg.sack;
  assign sstrb_o = r_reg.sstrb;
  assign attn_o = r_reg.attn;
  assign busy_o = r_reg.busy;
  assign selected_o = r_reg.sack;
  assign facility_o = r_reg.facility;
  assign shared_mode_o = shared;
  assign dir_in_o = dir_in;
  assign stream_o = stream;
  assign rx_data_o = r_reg.rx_data;
  assign rx_wide_o = r_reg.rx_wide;
  assign rx_valid_o = r_reg.rx_valid;
  assign tx_ready_o = r_reg.tx_ready;
  assign done_o = r_reg.done;
  assign status_o = r_reg.status;

  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  chk_one_change: assert property ( // [RULE1]
    $countones({sack_o, sstrb_o, attn_o} ^ $past({sack_o, sstrb_o, attn_o})) <= 1)
    else $error("more than one control line changed");

  chk_sel_answer: assert property ( // [RULE3]
    $rose(sack_o) |-> $past(s_sel) && !$past(busy_o))
    else $error("selection answered without master select");

  chk_addr_match: assert property ( // [RULE4]
    $rose(sack_o) |-> $past(s_a[2:0]) == SLAVE_ADDR && facility_o == $past(s_a[7:4]))
    else $error("wrong slave address or facility");

  chk_bc_unidir: assert property ( // [RULE6]
    r_reg.state == pbx_pkg::BC_ACK |-> !bus_a_oe_o && !bus_b_oe_o)
    else $error("lane driven during bus control");

  chk_no_fight: assert property ( // [RULE11]
    bus_a_oe_o |-> shared && dir_in && r_reg.state != pbx_pkg::ST_ACK)
    else $error("first lane driven while master may drive it");

  chk_status_lane: assert property ( // [RULE15]
    r_reg.state == pbx_pkg::ST_ACK |-> bus_b_oe_o && bus_b_o == status_o && sstrb_o)
    else $error("status not on second lane");

  chk_busy_refuse: assert property ( // [RULE19]
    busy_o && r_reg.state == pbx_pkg::IDLE |=> !sack_o)
    else $error("busy slave answered selection");

  chk_word_ack: assert property ( // [RULE2]
    r_reg.state == pbx_pkg::XO_ACK && s_sel && !s_mstrb |=> !sstrb_o && r_reg.state == pbx_pkg::XFER)
    else $error("word handshake not released");

  chk_end_status: assert property ( // [RULE8]
    r_reg.state == pbx_pkg::XFER && s_sel && s_mctl |=> r_reg.state == pbx_pkg::ST_SET ##1 sstrb_o)
    else $error("termination did not start status");

  cov_out_word: cover property (rx_valid_o && !stream);
  cov_in_word: cover property (r_reg.state == pbx_pkg::XI_DONE ##[1:50] done_o);
  cov_slave_end: cover property (attn_o ##[1:50] done_o);

endmodule : bus_slave_ctl

// [test/bus_master_model.sv]
/*
  Behavioural master for the peripheral bus slave: selection, bus control,
  words and ending status. Assumes the bench resolves the shared lanes.
*/
`timescale 1ns/1ns

module bus_master_model (
  input wire logic clk_i,
  input wire logic sack_i,
  input wire logic sstrb_i,
  input wire logic [7:0] a_i,
  input wire logic [7:0] b_i,
  output logic sel_o = 1'b0,
  output logic mctl_o = 1'b0,
  output logic mstrb_o = 1'b0,
  output logic [7:0] a_o,
  output logic [7:0] b_o
);
  logic [7:0] a_val = 8'h00;
  logic [7:0] b_val = 8'h00;
  logic [7:0] pat = 8'h5A;
  logic a_drv = 1'b1;
  logic b_drv = 1'b0;
  int lag = 0;
  int late = 0;

  // Released lanes show a pattern that flips every cycle
  always @(posedge clk_i) pat <= ~pat;
  assign a_o = a_drv ? a_val : pat;
  assign b_o = b_drv ? b_val : ~pat;

  // Waits for a slave line to settle at a level, then lingers
  task automatic wait_for(input bit strb, input logic lvl);
    int n = 0;
    while ((strb ? sstrb_i : sack_i) !== lvl && n < 60) begin
      @(negedge clk_i);
      n++;
    end
    if (n == 60) late++;
    repeat (lag) @(negedge clk_i);
  endtask : wait_for

  // Address octet first, then the select line
  task automatic select(input logic [7:0] oct, input bit ok);
    a_val = oct;
    a_drv = 1'b1;
    @(negedge clk_i);
    sel_o = 1'b1;
    if (ok) wait_for(0, 1'b1);
    else repeat (8) @(negedge clk_i);
  endtask : select

  // Drops selection and waits for the answer to go
  task automatic desel;
    @(negedge clk_i);
    sel_o = 1'b0;
    wait_for(0, 1'b0);
  endtask : desel

  // Bus control octet on the first lane, fully handshaked
  task automatic bus_ctl(input logic [7:0] oct);
    a_val = oct;
    @(negedge clk_i);
    mctl_o = 1'b1;
    wait_for(1, 1'b1);
    mctl_o = 1'b0;
    a_drv = !(oct[0] && oct[1]);
    b_drv = oct[0] && !oct[1];
    wait_for(1, 1'b0);
  endtask : bus_ctl

  // One handshaked word toward the slave
  task automatic out_word(input logic [15:0] w);
    a_val = w[7:0];
    b_val = w[15:8];
    @(negedge clk_i);
    mstrb_o = 1'b1;
    wait_for(1, 1'b1);
    mstrb_o = 1'b0;
    wait_for(1, 1'b0);
  endtask : out_word

  // One handshaked word from the slave, taken as first then second lane
  task automatic in_word(output logic [15:0] w);
    wait_for(1, 1'b1);
    w = {a_i, b_i};
    mstrb_o = 1'b1;
    wait_for(1, 1'b0);
    mstrb_o = 1'b0;
    repeat (4) @(negedge clk_i);
  endtask : in_word

  // Streamed strobes with no acknowledge awaited
  task automatic stream_out(input int n);
    repeat (n) begin
      mstrb_o = 1'b1;
      repeat (4) @(negedge clk_i);
      mstrb_o = 1'b0;
      repeat (4) @(negedge clk_i);
    end
  endtask : stream_out

  // Ending status sequence closing each bus control that is not aborted by deselection
  task automatic end_seq(output logic [7:0] st);
    b_drv = 1'b0; // Second lane handed over for slave status
    @(negedge clk_i);
    mctl_o = 1'b1;
    wait_for(1, 1'b1);
    st = b_i;
    mctl_o = 1'b0;
    wait_for(1, 1'b0);
    a_drv = 1'b1;
    b_drv = 1'b0;
  endtask : end_seq
endmodule : bus_master_model

// [test/peripheral_bus_exchange_framing_tb_top.sv]
/*
  Self-checking bench for the bus slave controller with a master model.
  Assumes a 50 MHz clock and lanes resolved here from both enables.
*/
`timescale 1ns/1ns

module peripheral_bus_exchange_framing_tb_top;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic busy_req_i = 1'b0;
  logic end_req_i = 1'b0;
  logic tx_valid_i = 1'b0;
  logic [15:0] tx_data_i = 16'h0000;
  logic sel, mctl, mstrb, a_oe, b_oe, sack, sstrb, attn, busy, done, rx_valid, tx_ready;
  logic selected, shared_m, dir_in_m, stream_m, rx_wide;
  logic rx_ready_i = 1'b1;
  logic [7:0] status;
  logic [3:0] fac;
  logic [7:0] m_a, m_b, d_a, d_b, a_w, b_w, st;
  logic [15:0] rx_data, rx_q, w;
  int num_errors = 0;
  int check_count = 0;
  int rx_n = 0;
  int done_n = 0;

  // Lane levels from both parties
  assign a_w = a_oe ? d_a : m_a;
  assign b_w = b_oe ? d_b : m_b;

  bus_master_model master (.clk_i(clk_i), .sack_i(sack), .sstrb_i(sstrb), .a_i(a_w),
    .b_i(b_w), .sel_o(sel), .mctl_o(mctl), .mstrb_o(mstrb), .a_o(m_a), .b_o(m_b));

  bus_slave_ctl dut (.clk_i(clk_i), .rstn_i(rstn_i), .sel_i(sel), .mctl_i(mctl),
    .mstrb_i(mstrb), .bus_a_i(a_w), .bus_a_o(d_a), .bus_a_oe_o(a_oe), .bus_b_i(b_w),
    .bus_b_o(d_b), .bus_b_oe_o(b_oe), .sack_o(sack), .sstrb_o(sstrb), .attn_o(attn),
    .busy_o(busy), .busy_req_i(busy_req_i), .end_req_i(end_req_i), .selected_o(selected),
    .facility_o(fac), .shared_mode_o(shared_m), .dir_in_o(dir_in_m), .stream_o(stream_m),
    .rx_data_o(rx_data), .rx_wide_o(rx_wide), .rx_valid_o(rx_valid), .rx_ready_i(rx_ready_i),
    .tx_data_i(tx_data_i), .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready), .done_o(done),
    .status_o(status));

  // Clock at 20 ns
  initial forever #10 clk_i = ~clk_i;

  // Counts received words and finished exchanges
  always @(posedge clk_i) begin
    if (rx_valid === 1'b1) begin
      rx_q = rx_data;
      rx_n++;
    end
    if (done === 1'b1) done_n++;
    if (a_oe === 1'b1 || b_oe === 1'b1) begin
      check({a_oe && master.a_drv, b_oe && master.b_drv}, 2'h0);
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up;
    if (num_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up

  // Offers one word to send and withdraws it once taken
  task automatic send(input logic [15:0] d);
    int n = 0;
    tx_data_i = d;
    tx_valid_i = 1'b1;
    while (tx_ready !== 1'b1 && n < 40) begin
      @(negedge clk_i);
      n++;
    end
    tx_valid_i = 1'b0;
  endtask : send

  // Ending sequence with its status and one completion pulse
  task automatic run_end(input logic [7:0] mask, input logic [7:0] exp);
    int d0 = done_n;
    master.end_seq(st);
    repeat (2) @(negedge clk_i);
    check(st & mask, exp);
    check(status & mask, exp);
    check(16'(done_n - d0), 16'h0001);
    check(selected, 1'b1);
  endtask : run_end

  // Bus control through the master, then the latched configuration
  task automatic do_ctl(input logic [7:0] oct);
    master.bus_ctl(oct);
    check({stream_m, dir_in_m, shared_m}, oct[2:0]);
  endtask : do_ctl

  // Wrong address and busy both refuse selection
  task automatic t_refuse;
    master.select(8'h05, 0);
    check(sack, 1'b0);
    master.desel();
    busy_req_i = 1'b1;
    repeat (3) @(negedge clk_i);
    check(busy, 1'b1);
    master.select(8'h00, 0);
    check(sack, 1'b0);
    master.desel();
    busy_req_i = 1'b0;
    repeat (3) @(negedge clk_i);
  endtask : t_refuse

  // Split mode words toward the slave with extreme payloads
  task automatic t_split_out;
    logic [7:0] v[3] = '{8'h00, 8'hFF, 8'h3C};
    int n0;
    do_ctl(8'h00);
    foreach (v[i]) begin
      master.out_word({~v[i], v[i]});
      check(rx_q, {8'h00, v[i]});
    end
    check(rx_wide, 1'b0);
    rx_ready_i = 1'b0;
    n0 = rx_n;
    fork
      master.out_word(16'h0099);
      begin
        repeat (10) @(negedge clk_i);
        check(16'(rx_n - n0), 16'h0000);
        check(sstrb, 1'b0);
        rx_ready_i = 1'b1;
      end
    join
    check(rx_q, 16'h0099);
    check({a_oe, b_oe}, 2'h1);
    run_end(8'hFF, 8'h04);
  endtask : t_split_out

  // Split mode word from the slave, then the slave asks to end
  task automatic t_split_in;
    int n = 0;
    do_ctl(8'h02);
    fork
      master.in_word(w);
      send(16'hC3A5);
    join
    check(w[7:0], 8'hA5);
    check(a_oe, 1'b0);
    end_req_i = 1'b1;
    while (attn !== 1'b1 && n < 10) begin
      @(negedge clk_i);
      n++;
    end
    check(attn, 1'b1);
    end_req_i = 1'b0;
    run_end(8'h03, 8'h01);
  endtask : t_split_in

  // Shared mode in both directions, the master slow to answer
  task automatic t_shared;
    master.lag = 3;
    do_ctl(8'h03);
    fork
      master.in_word(w);
      send(16'h5AC3);
    join
    check(w, 16'h5AC3);
    run_end(8'hFF, 8'h04);
    do_ctl(8'h01);
    master.out_word(16'hE718);
    check(rx_q, 16'hE718);
    check(rx_wide, 1'b1);
    check({a_oe, b_oe}, 2'h0);
    run_end(8'hFF, 8'h04);
    master.lag = 0;
  endtask : t_shared

  // Empty frame and a streamed burst
  task automatic t_empty_stream;
    int n0;
    do_ctl(8'h00);
    run_end(8'hFF, 8'h06);
    do_ctl(8'h04);
    n0 = rx_n;
    master.stream_out(3);
    check(16'(rx_n - n0), 16'h0003);
    check(sstrb, 1'b0);
    run_end(8'hFF, 8'h04);
  endtask : t_empty_stream

  // Maintenance: abort a frame by deselection, reset, then a clean frame
  task automatic t_recover;
    do_ctl(8'h02);
    end_req_i = 1'b1;
    repeat (3) @(negedge clk_i);
    master.desel();
    end_req_i = 1'b0;
    check({sack, sstrb, attn, a_oe, b_oe}, 5'h00);
    rstn_i = 1'b0;
    repeat (2) @(negedge clk_i);
    rstn_i = 1'b1;
    check({status, selected, busy}, 10'h000);
    master.select(8'h30, 1);
    check(fac, 4'h3);
    do_ctl(8'h00);
    run_end(8'hFF, 8'h06);
  endtask : t_recover

  // Watchdog well beyond the expected run
  initial begin
    #1000000;
    num_errors++;
    wrap_up();
  end

  // Main sequence
  initial begin
    repeat (5) @(negedge clk_i);
    rstn_i = 1'b1;
    check({sack, sstrb, attn, a_oe, b_oe}, 5'h00);
    t_refuse();
    master.select(8'hF0, 1);
    check(fac, 4'hF);
    check(selected, 1'b1);
    t_split_out();
    t_split_in();
    t_shared();
    t_empty_stream();
    t_recover();
    master.desel();
    check(sack, 1'b0);
    check(selected, 1'b0);
    check(16'(master.late), 16'h0000);
    wrap_up();
  end
endmodule : peripheral_bus_exchange_framing_tb_top
